// [common/prio_bank_params.svh]
/*
 * Constants of the priority configuration bank: register offsets, field
 * positions, reset values and read masks.
 * Assumes inclusion by bare name from files that need these numbers.
 */
`ifndef PRIO_BANK_PARAMS_SVH
`define PRIO_BANK_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the APB bus.
// ----------------------------------------------------------------------
`define OFF_PRIO0     12'h000
`define OFF_PRIO1     12'h004
`define OFF_PRIO2     12'h008
`define OFF_PRIO3     12'h00c
`define OFF_PRIO4     12'h010
`define OFF_PRIO5     12'h014
`define OFF_FLAG      12'h020
`define OFF_ENABLE    12'h024
`define OFF_IRQ_STAT  12'h028
`define OFF_IRQ_MASK  12'h02c
`define OFF_WINNER    12'h030

// ----------------------------------------------------------------------
// Field layout and reset values.
// ----------------------------------------------------------------------
`define NUM_SRC       21
`define NUM_PRIO_REG  6
`define LVL_W         3
`define LVL_RESET     3'h4
`define LVL_OFF       3'h0
`define FIELD_LSB0    0
`define FIELD_LSB1    4
`define FIELD_LSB2    8
`define FIELD_LSB3    12
`define MASK_FULL     16'h7777
`define MASK_NO_LOW   16'h7770
`define MASK_NO_HIGH  16'h0777
`define RESET_FULL    16'h4444
`define RESET_NO_LOW  16'h4440
`define RESET_NO_HIGH 16'h0444

// ----------------------------------------------------------------------
// Interrupt status bit positions.
// ----------------------------------------------------------------------
`define IRQ_NEW_WIN   0
`define IRQ_LOST_REQ  1

`endif

// [common/prio_bank_pkg.sv]
/*
 * Types of the priority configuration bank.
 * Assumes the constants header is compiled alongside.
 */
`include "prio_bank_params.svh"

package prio_bank_pkg;

    // Bus slave phases, one-hot.
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_t;

    // Whole state of the top module.
    typedef struct packed {
        bus_state_t                               bus;
        logic [`NUM_PRIO_REG-1:0][15:0]           prio;
        logic [`NUM_SRC-1:0]                      flag;
        logic [`NUM_SRC-1:0]                      enable;
        logic [1:0]                               irq_stat;
        logic [1:0]                               irq_mask;
        logic [31:0]                              prdata;
        logic                                     pready;
        logic                                     pslverr;
        logic                                     irq;
        logic                                     req;
        logic [`LVL_W-1:0]                        req_lvl;
        logic [4:0]                               req_id;
    } bank_state_t;

endpackage

// [hw/prio_arbiter.sv]
/*
 * Combinational priority picker over all sources.
 * Assumes levels, flags and enables are registered by the caller.
 */
`timescale 1ns/100ps
`default_nettype none

`include "prio_bank_params.svh"

module prio_arbiter
    import prio_bank_pkg::*;
(
    // Per-source inputs.
    input  wire logic [`NUM_SRC*`LVL_W-1:0] levels,
    input  wire logic [`NUM_SRC-1:0]        flags,
    input  wire logic [`NUM_SRC-1:0]        enables,
    // Winner.
    output logic                            win_valid,
    output logic [`LVL_W-1:0]               win_lvl,
    output logic [4:0]                      win_id
);

    // Lowest source index wins a tie because only a strictly higher level
    // replaces the current pick; level zero never qualifies.
    always_comb begin
        logic [`LVL_W-1:0] lvl;
        lvl       = `LVL_OFF;
        win_valid = 1'b0;
        win_lvl   = `LVL_OFF;
        win_id    = 5'h00;
        for (int i = 0; i < `NUM_SRC; i++) begin
            lvl = levels[i*`LVL_W +: `LVL_W];
            if (flags[i] && enables[i] && lvl > win_lvl) begin
                win_valid = 1'b1;
                win_lvl   = lvl;
                win_id    = 5'(i);
            end
        end
    end

endmodule

`default_nettype wire

// [hw/prio_config_bank.sv]
/*
 * Priority configuration bank: six priority registers for 21 sources,
 * request flags and enables, an arbiter and an APB slave.
 * Assumes a single 100 MHz clock; request pulses come from logic on pclk.
 */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

`include "prio_bank_params.svh"

module prio_config_bank
    import prio_bank_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    clk_en,
    // APB slave.
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Source request pulses, same clock.
    input  wire logic [`NUM_SRC-1:0]     src_event,
    // Toward the core.
    output logic                         core_req,
    output logic [`LVL_W-1:0]            core_lvl,
    output logic [4:0]                   core_src,
    output logic                         irq
);

    // ------------------------------------------------------------------
    // State and constants
    // ------------------------------------------------------------------
    bank_state_t q, d;

    // Read masks of the six registers; anything outside reads as zero.
    localparam logic [`NUM_PRIO_REG-1:0][15:0] RD_MASK = {
        `MASK_NO_HIGH, `MASK_FULL, `MASK_NO_HIGH,
        `MASK_FULL, `MASK_NO_LOW, `MASK_FULL};
    localparam logic [`NUM_PRIO_REG-1:0][15:0] RST_VAL = {
        `RESET_NO_HIGH, `RESET_FULL, `RESET_NO_HIGH,
        `RESET_FULL, `RESET_NO_LOW, `RESET_FULL};

    // ------------------------------------------------------------------
    // Field unpacking: source index order is the tie-break order.
    // ------------------------------------------------------------------
    logic [`NUM_SRC*`LVL_W-1:0] levels;
    logic                       win_valid;
    logic [`LVL_W-1:0]          win_lvl;
    logic [4:0]                 win_id;

    // Sources 0-3 register 0, 4-6 register 1, 7-10 register 2, 11-13
    // register 3, 14-17 register 4, 18-20 register 5, high field first.
    // Within a register the lowest field is the lowest source index, so the
    // concatenation lists each register from its top field down.
    assign levels = {
        q.prio[5][`FIELD_LSB2 +: 3], q.prio[5][`FIELD_LSB1 +: 3],
        q.prio[5][`FIELD_LSB0 +: 3],
        q.prio[4][`FIELD_LSB3 +: 3], q.prio[4][`FIELD_LSB2 +: 3],
        q.prio[4][`FIELD_LSB1 +: 3], q.prio[4][`FIELD_LSB0 +: 3],
        q.prio[3][`FIELD_LSB2 +: 3], q.prio[3][`FIELD_LSB1 +: 3],
        q.prio[3][`FIELD_LSB0 +: 3],
        q.prio[2][`FIELD_LSB3 +: 3], q.prio[2][`FIELD_LSB2 +: 3],
        q.prio[2][`FIELD_LSB1 +: 3], q.prio[2][`FIELD_LSB0 +: 3],
        q.prio[1][`FIELD_LSB3 +: 3], q.prio[1][`FIELD_LSB2 +: 3],
        q.prio[1][`FIELD_LSB1 +: 3],
        q.prio[0][`FIELD_LSB3 +: 3], q.prio[0][`FIELD_LSB2 +: 3],
        q.prio[0][`FIELD_LSB1 +: 3], q.prio[0][`FIELD_LSB0 +: 3]};

    // Fields hold the level directly, so 111 is 7 and 001 is 1.
    prio_arbiter u_arb (
        .levels    (levels),
        .flags     (q.flag),
        .enables   (q.enable),
        .win_valid (win_valid),
        .win_lvl   (win_lvl),
        .win_id    (win_id)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic        wr_acc;
    logic        rd_acc;
    logic        known;
    logic [31:0] rd_mux;

    // The setup is taken at one edge, the access cycle registers the answer,
    // and ready stands in the cycle after it; the answer costs one wait state
    // because every output must come straight from a flip-flop.
    always_comb begin
        d        = q;
        wr_acc   = 1'b0;
        rd_acc   = 1'b0;
        known    = 1'b1;
        rd_mux   = 32'h0000_0000;
        d.pready = 1'b0;
        d.prdata = 32'h0000_0000;
        case (paddr)
            `OFF_PRIO0:    rd_mux = {16'h0000, q.prio[0] & RD_MASK[0]};
            `OFF_PRIO1:    rd_mux = {16'h0000, q.prio[1] & RD_MASK[1]};
            `OFF_PRIO2:    rd_mux = {16'h0000, q.prio[2] & RD_MASK[2]};
            `OFF_PRIO3:    rd_mux = {16'h0000, q.prio[3] & RD_MASK[3]};
            `OFF_PRIO4:    rd_mux = {16'h0000, q.prio[4] & RD_MASK[4]};
            `OFF_PRIO5:    rd_mux = {16'h0000, q.prio[5] & RD_MASK[5]};
            `OFF_FLAG:     rd_mux = {11'h000, q.flag};
            `OFF_ENABLE:   rd_mux = {11'h000, q.enable};
            `OFF_IRQ_STAT: rd_mux = {30'h0000_0000, q.irq_stat};
            `OFF_IRQ_MASK: rd_mux = {30'h0000_0000, q.irq_mask};
            `OFF_WINNER:   rd_mux = {23'h00_0000, q.req, q.req_lvl, q.req_id};
            default:       known  = 1'b0;
        endcase
        case (q.bus)
            BUS_IDLE: begin
                if (psel && !penable) begin
                    d.bus = BUS_ACCESS;
                end
            end
            BUS_ACCESS: begin
                d.bus     = BUS_IDLE;
                d.pready  = 1'b1;
                d.pslverr = !known;
                rd_acc    = psel && !pwrite;
                d.prdata  = rd_acc && known ? rd_mux : 32'h0000_0000;
            end
            default: d.bus = BUS_IDLE;
        endcase
        // The write lands at the edge that samples the registered ready with
        // the request still held, the same edge at which the master ends it.
        wr_acc = q.pready && psel && penable && pwrite && known;
        // Hardware sets flags; a same-cycle software clear loses to a new event.
        d.flag = q.flag | src_event;
        if (wr_acc) begin
            case (paddr)
                `OFF_PRIO0: d.prio[0] = pwdata[15:0] & RD_MASK[0];
                `OFF_PRIO1: d.prio[1] = pwdata[15:0] & RD_MASK[1];
                `OFF_PRIO2: d.prio[2] = pwdata[15:0] & RD_MASK[2];
                `OFF_PRIO3: d.prio[3] = pwdata[15:0] & RD_MASK[3];
                `OFF_PRIO4: d.prio[4] = pwdata[15:0] & RD_MASK[4];
                `OFF_PRIO5: d.prio[5] = pwdata[15:0] & RD_MASK[5];
                `OFF_FLAG:  d.flag = (q.flag & ~pwdata[`NUM_SRC-1:0]) | src_event;
                `OFF_ENABLE:   d.enable   = pwdata[`NUM_SRC-1:0];
                `OFF_IRQ_MASK: d.irq_mask = pwdata[1:0];
                `OFF_IRQ_STAT: d.irq_stat = q.irq_stat & ~pwdata[1:0];
                default: d.irq_mask = q.irq_mask;
            endcase
        end
        // Sticky events: a new winner, and an event dropped on a disabled
        // source; the set beats a same-cycle clear.
        if (win_valid && (!q.req || win_id != q.req_id)) begin
            d.irq_stat[`IRQ_NEW_WIN] = 1'b1;
        end
        if (|(src_event & ~q.enable)) begin
            d.irq_stat[`IRQ_LOST_REQ] = 1'b1;
        end
        // Winner registered one edge after the field changed.
        d.req     = win_valid;
        d.req_lvl = win_lvl;
        d.req_id  = win_id;
        d.irq     = |(d.irq_stat & d.irq_mask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Clock enable low freezes everything including the bus answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.bus      <= BUS_IDLE;
            q.prio     <= RST_VAL;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign prdata   = q.prdata;
    assign pready   = q.pready;
    assign pslverr  = q.pslverr;
    assign core_req = q.req;
    assign core_lvl = q.req_lvl;
    assign core_src = q.req_id;
    assign irq      = q.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ((q.prio[1] & ~`MASK_NO_LOW) == 16'h0000) && ((q.prio[3] & ~`MASK_NO_HIGH) == 16'h0000))
        else $error("Unimplemented priority bits are set.");

    a_zero_never_wins: assert property (@(posedge pclk) disable iff (!presetn)
        core_req |-> core_lvl != `LVL_OFF)
        else $error("Disabled level forwarded to core.");

    a_disabled_src_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && q.enable == '0) |=> !core_req)
        else $error("Request forwarded with all sources disabled.");

    a_write_next_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && wr_acc && paddr == `OFF_PRIO0) |=> q.prio[0] == ($past(pwdata[15:0]) & `MASK_FULL))
        else $error("Priority write not applied on next edge.");

    a_top_level_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && win_valid) |=> core_req && core_lvl == $past(win_lvl))
        else $error("Winner level not forwarded.");

    a_level_seven: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && q.flag[0] && q.enable[0] && q.prio[0][2:0] == 3'h7) |=> core_lvl == 3'h7)
        else $error("Level seven source not at top.");

    a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && psel && !penable && q.bus == BUS_IDLE) |-> ##2 (pready || !clk_en))
        else $error("APB access not answered after one wait cycle.");

    a_reset_level: assert property (@(posedge pclk)
        $rose(presetn) |-> q.prio[2] == `RESET_FULL)
        else $error("Priority field did not reset to level four.");

    // Every register leaves reset with all its implemented fields at level four.
    a_reset_all_fields: assert property (@(posedge pclk)
        $rose(presetn) |-> q.prio == RST_VAL)
        else $error("Priority bank did not reset to level four.");

    // The last register keeps its top five bits empty.
    a_upper_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ((q.prio[5] & ~`MASK_NO_HIGH) == 16'h0000) && ((q.prio[0] & ~`MASK_FULL) == 16'h0000))
        else $error("Unimplemented upper priority bits are set.");

    // Level one is the lowest level that still raises a request.
    a_level_one_requests: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && q.flag[0] && q.enable[0] && q.prio[0][2:0] == 3'h1) |=> core_req)
        else $error("Level one source did not request.");

    // With every field at zero nothing reaches the core, whatever the flags.
    a_all_fields_off: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && q.prio == '0) |=> !core_req)
        else $error("Request forwarded with every level at zero.");

    // Ready is a one-cycle pulse so a master never sees two completions.
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && pready) |=> !pready)
        else $error("APB ready held for more than one cycle.");

    // A pulse sets its flag even when software clears it in the same cycle.
    a_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && src_event != '0) |=> (q.flag & $past(src_event)) == $past(src_event))
        else $error("Source event did not set its flag.");

    // A pulse on a disabled source is recorded instead of requesting.
    a_lost_event_seen: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && (src_event & ~q.enable) != '0) |=> q.irq_stat[`IRQ_LOST_REQ])
        else $error("Event on disabled source not recorded.");

    // The interrupt line follows the masked status at all times.
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        irq == ((q.irq_stat & q.irq_mask) != 2'b00))
        else $error("Interrupt line disagrees with masked status.");

endmodule

`default_nettype wire

// [bench/event_source_model.sv]
/*
 * Model of the peripheral logic that raises one-cycle request pulses.
 * Assumes the bench commands it on pclk and the bank samples on pclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "prio_bank_params.svh"
module event_source_model (
    // Clock and reset.
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Command from the bench.
    input  wire logic                fire_req,
    input  wire logic [`NUM_SRC-1:0] fire_mask,
    // Pulses into the bank.
    output logic [`NUM_SRC-1:0]      src_event
);
    // A pulse lasts one cycle so a level never sets a flag twice.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_event <= '0;
        end else begin
            src_event <= fire_req ? fire_mask : '0;
        end
    end
endmodule
`default_nettype wire

// [bench/prio_config_bank_tb.sv]
/*
 * Self-checking bench of the priority configuration bank over APB.
 * Assumes the design, its package and the event source model compile first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "prio_bank_params.svh"
module prio_config_bank_tb;
    // ------------------------------------------------------------------
    // Signals and tables.
    // ------------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        core_req, irq, fire_req, er, clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  core_lvl;
    logic [4:0]  core_src;
    logic [20:0] src_event, fire_mask;
    int          err_count, total_checks, cycles;
    logic [15:0] rst_val [6] = '{16'h4444, 16'h4440, 16'h4444, 16'h0444, 16'h4444, 16'h0444};
    logic [15:0] rw_mask [6] = '{16'h7777, 16'h7770, 16'h7777, 16'h0777, 16'h7777, 16'h0777};
    int          src_reg [21] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5, 5};
    int          src_lsb [21] = '{0, 4, 8, 12, 4, 8, 12, 0, 4, 8, 12, 0, 4, 8, 0, 4, 8, 12, 0, 4, 8};

    prio_config_bank uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_event(src_event), .core_req(core_req),
        .core_lvl(core_lvl), .core_src(core_src), .irq(irq));
    event_source_model model (.pclk(pclk), .presetn(presetn), .fire_req(fire_req),
        .fire_mask(fire_mask), .src_event(src_event));

    // ------------------------------------------------------------------
    // Clock, timeout and tasks.
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // A run still going at cycle 20000 is ended with one more mismatch counted.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen high or 20 cycles have passed.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic fire(input logic [20:0] m);
        @(posedge pclk);
        fire_req <= 1'b1;
        fire_mask <= m;
        @(posedge pclk);
        fire_req <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, fire_req} = '0;
        clk_en = 1'b1;
        paddr = '0;
        pwdata = '0;
        fire_mask = '0;
        {err_count, total_checks, cycles} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then all ones and all zeros through every priority register.
        for (int r = 0; r < 6; r++) begin
            apb(1'b0, 12'(4 * r), 32'h0);
            check(rd, {16'h0, rst_val[r]});
            apb(1'b1, 12'(4 * r), 32'hffffffff);
            apb(1'b0, 12'(4 * r), 32'h0);
            check(rd, {16'h0, rw_mask[r]});
            apb(1'b1, 12'(4 * r), 32'h0);
            apb(1'b0, 12'(4 * r), 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 12'h040, 32'h0);
        check({rd[30:0], er}, 32'h1);
        // Each source alone at level 7 must win under its own index.
        apb(1'b1, `OFF_ENABLE, 32'h001fffff);
        for (int s = 0; s < 21; s++) begin
            apb(1'b1, 12'(4 * src_reg[s]), 32'h7 << src_lsb[s]);
            fire(21'h1 << s);
            tick(3);
            check(32'({core_req, core_lvl, core_src}), 32'({4'hf, 5'(s)}));
            apb(1'b1, `OFF_FLAG, 32'h1 << s);
            apb(1'b1, 12'(4 * src_reg[s]), 32'h0);
        end
        // Equal levels, a raised level, a disabled field, a cleared enable.
        apb(1'b1, `OFF_PRIO0, 32'h0011);
        fire(21'h3);
        tick(3);
        check(32'({core_req, core_lvl, core_src}), 32'h120);
        apb(1'b0, `OFF_WINNER, 32'h0);
        check(rd, 32'h120);
        apb(1'b1, `OFF_PRIO0, 32'h0021);
        tick(2);
        check(32'({core_req, core_lvl, core_src}), 32'h141);
        apb(1'b1, `OFF_PRIO0, 32'h0001);
        tick(2);
        check(32'({core_req, core_lvl, core_src}), 32'h120);
        apb(1'b1, `OFF_ENABLE, 32'h001ffffe);
        fire(21'h1);
        tick(2);
        check(32'(core_req), 32'h0);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        check(rd & 32'h2, 32'h2);
        // Interrupt raised, cleared, then masked while the status still sets.
        apb(1'b1, `OFF_ENABLE, 32'h001fffff);
        apb(1'b1, `OFF_FLAG, 32'h001fffff);
        apb(1'b1, `OFF_IRQ_STAT, 32'h3);
        apb(1'b1, `OFF_IRQ_MASK, 32'h1);
        tick(2);
        check(32'(irq), 32'h0);
        fire(21'h1);
        tick(3);
        check(32'(irq), 32'h1);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, `OFF_IRQ_STAT, 32'h1);
        apb(1'b1, `OFF_IRQ_MASK, 32'h0);
        apb(1'b1, `OFF_FLAG, 32'h1);
        tick(2);
        check(32'(irq), 32'h0);
        fire(21'h1);
        tick(3);
        check(32'(irq), 32'h0);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        check(rd, 32'h1);
        // A low clock enable freezes the bank, so a pulse meanwhile is lost.
        apb(1'b1, `OFF_FLAG, 32'h1);
        clk_en <= 1'b0;
        fire(21'h1);
        tick(2);
        clk_en <= 1'b1;
        tick(2);
        check(32'(core_req), 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
